// ===== src/amc_pkg.sv
// Constants and types shared by the acquisition mode control block.
//------------------------------------------------------------------
//------------------------------------------------------------------
package amc_pkg;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTL  = 8'h0A;
    localparam logic [7:0] ADDR_TAH  = 8'h0B;
    localparam logic [7:0] ADDR_TAL  = 8'h0C;
    localparam logic [7:0] ADDR_ITH  = 8'h0D;
    localparam logic [7:0] ADDR_ITL  = 8'h0E;
    localparam logic [7:0] ADDR_STAT = 8'h1F;

    // Reset values.
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [7:0] RST_TAH = 8'h80;
    localparam logic [7:0] RST_TAL = 8'h00;
    localparam logic [7:0] RST_ITH = 8'h00;
    localparam logic [7:0] RST_ITL = 8'h00;

    // Field positions in the mode control register and the period high byte.
    localparam int CTL_MODE_HI  = 7;
    localparam int CTL_MODE_LO  = 6;
    localparam int CTL_SKIP_HI  = 5;
    localparam int CTL_SKIP_LO  = 3;
    localparam int CTL_CHOP     = 2;
    localparam int CTL_IND      = 1;
    localparam int CTL_START    = 0;
    localparam int TAH_UNIT     = 7;

    // Mode field codes.
    localparam logic [1:0] MODE_NOM1 = 2'h0;
    localparam logic [1:0] MODE_NOM2 = 2'h1;
    localparam logic [1:0] MODE_STANDBY_MODE_ONE = 2'h2;
    localparam logic [1:0] MODE_STANDBY_THRESHOLD_MODE = 2'h3;

    // Discarded sample count for skip code zero.
    localparam logic [3:0] SKIP_BASE = 4'h3;

    // Timing: clock rate and the two period units.
    localparam int CLK_HZ    = 40_000_000;
    localparam int UNIT_MS   = 1;
    localparam int UNIT_S    = 1;
    localparam int MS_CYC    = CLK_HZ / 1000 * UNIT_MS;
    localparam int S_CYC     = CLK_HZ * UNIT_S;
    localparam int CHOP_HALF = 20;

    typedef enum logic [1:0] {
        ST_STOP,
        ST_NORM,
        ST_WAIT,
        ST_ACQ
    } amc_state_t;

endpackage

// ===== src/amc_tmr_if.sv
// Interface between the mode controller and its period timer.
`timescale 1ns/10ps
`default_nettype none
interface amc_tmr_if;
    logic        run;
    logic        unit_sec;
    logic [14:0] period;
    logic        expire;

    modport ctrl  (output run, output unit_sec, output period, input expire);
    modport timer (input run, input unit_sec, input period, output expire);
endinterface
`default_nettype wire

// ===== src/amc_period_timer.sv
// Standby period timer: unit prescaler and period counter.
`timescale 1ns/10ps
`default_nettype none
module amc_period_timer #(
    parameter int MS_CYC = amc_pkg::MS_CYC,
    parameter int S_CYC  = amc_pkg::S_CYC
) (
    // Clock and reset.
    input wire logic     sys_clk_i,
    input wire logic     srst_i,
    // Controller side.
    amc_tmr_if.timer     tmr
);
    localparam int PW = $clog2(S_CYC + 1);

    logic [PW-1:0] pre_q;
    logic [14:0]   cnt_q;
    logic          exp_q;
    logic [PW-1:0] lim;

    // Unit length picked by the unit bit; a zero period acts as one unit.
    assign lim = tmr.unit_sec ? PW'(S_CYC - 1) : PW'(MS_CYC - 1);
    assign tmr.expire = exp_q;

    // Counts whole units and pulses once per period while running.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !tmr.run) begin
            pre_q <= '0;
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            exp_q <= 1'b0;
            if (pre_q >= lim) begin
                pre_q <= '0;
                if (cnt_q + 15'h0001 >= tmr.period) begin
                    cnt_q <= '0;
                    exp_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 15'h0001;
                end
            end else begin
                pre_q <= pre_q + PW'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/amc_mode_ctrl.sv
// Acquisition mode control: register group, mode sequencer and pins.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module amc_mode_ctrl #(
    parameter int MS_CYC    = amc_pkg::MS_CYC,
    parameter int S_CYC     = amc_pkg::S_CYC,
    parameter int CHOP_HALF = amc_pkg::CHOP_HALF
) (
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // Register port.
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    output logic      [7:0]  rd_data_o,
    // Measurement datapath.
    input  wire logic        sample_valid_i,
    input  wire logic [15:0] sample_current_i,
    output logic             acq_run_o,
    output logic             acq_nom2_o,
    output logic             acq_shot_o,
    // Device pins.
    output logic             chopper_clock_output_o,
    output logic             mode_change_indicator_pin_o
);

    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    localparam int CW = $clog2(CHOP_HALF + 1);

    logic [7:0]          ctl_q;
    logic [7:0]          tah_q;
    logic [7:0]          tal_q;
    logic [7:0]          ith_q;
    logic [7:0]          itl_q;
    logic [14:0]         per_act_q;
    logic                unit_act_q;
    logic [15:0]         thr_act_q;
    amc_pkg::amc_state_t state_q;
    amc_pkg::amc_state_t st_d;
    logic [3:0]          skip_cnt_q;
    logic [3:0]          skip_lim;
    logic                woke_q;
    logic                wake;
    logic [CW-1:0]       chop_cnt_q;
    logic [1:0]          mode;
    logic                stby;
    logic                start;
    logic                ctl_wr;

    amc_tmr_if tmr_if ();

    assign mode   = ctl_q[amc_pkg::CTL_MODE_HI:amc_pkg::CTL_MODE_LO];
    assign stby   = mode[1];
    assign start  = ctl_q[amc_pkg::CTL_START];
    assign ctl_wr = wr_en_i && addr_i == amc_pkg::ADDR_CTL;

    // Skip code 000..111 means 3..10 discarded samples.
    assign skip_lim = {1'b0, ctl_q[amc_pkg::CTL_SKIP_HI:amc_pkg::CTL_SKIP_LO]}
                      + amc_pkg::SKIP_BASE;

    //------------------------------------------------------------------
    // Register file
    //------------------------------------------------------------------
    // Software writes; every register but status is plain read/write storage.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctl_q <= amc_pkg::RST_CTL;
            tah_q <= amc_pkg::RST_TAH;
            tal_q <= amc_pkg::RST_TAL;
            ith_q <= amc_pkg::RST_ITH;
            itl_q <= amc_pkg::RST_ITL;
        end else if (wr_en_i) begin
            case (addr_i)
                amc_pkg::ADDR_CTL: ctl_q <= wr_data_i;
                amc_pkg::ADDR_TAH: tah_q <= wr_data_i;
                amc_pkg::ADDR_TAL: tal_q <= wr_data_i;
                amc_pkg::ADDR_ITH: ith_q <= wr_data_i;
                amc_pkg::ADDR_ITL: itl_q <= wr_data_i;
                default: ;
            endcase
        end
    end

    // Working copies load only on the low-byte write, so the sequencer
    // never sees a half-updated period or threshold. Software must
    // write the high byte first.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            per_act_q  <= {amc_pkg::RST_TAH[6:0], amc_pkg::RST_TAL};
            unit_act_q <= amc_pkg::RST_TAH[amc_pkg::TAH_UNIT];
            thr_act_q  <= {amc_pkg::RST_ITH, amc_pkg::RST_ITL};
        end else if (wr_en_i) begin
            if (addr_i == amc_pkg::ADDR_TAL) begin
                per_act_q  <= {tah_q[6:0], wr_data_i};
                unit_act_q <= tah_q[amc_pkg::TAH_UNIT];
            end
            if (addr_i == amc_pkg::ADDR_ITL) begin
                thr_act_q <= {ith_q, wr_data_i};
            end
        end
    end

    // Status word: stop, normal, standby, woken by threshold.
    function automatic logic [7:0] status_word(amc_pkg::amc_state_t s,
                                               logic w);
        logic [7:0] v;
        v = 8'h00;
        case (s)
            amc_pkg::ST_STOP: v[0] = 1'b1;
            amc_pkg::ST_NORM: v[1] = 1'b1;
            default:          v[2] = 1'b1;
        endcase
        v[3] = w;
        return v;
    endfunction

    // Read data stand one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_en_i) begin
            case (addr_i)
                amc_pkg::ADDR_CTL:  rd_data_o <= ctl_q;
                amc_pkg::ADDR_TAH:  rd_data_o <= tah_q;
                amc_pkg::ADDR_TAL:  rd_data_o <= tal_q;
                amc_pkg::ADDR_ITH:  rd_data_o <= ith_q;
                amc_pkg::ADDR_ITL:  rd_data_o <= itl_q;
                amc_pkg::ADDR_STAT: rd_data_o <= status_word(state_q, woke_q);
                default:            rd_data_o <= 8'h00;
            endcase
        end else begin
            rd_data_o <= 8'h00;
        end
    end

    //------------------------------------------------------------------
    // Period timer
    //------------------------------------------------------------------
    // The timer runs through acquisition too, so shots keep the period
    // exactly; a period shorter than one acquisition drops shots.
    assign tmr_if.run      = state_q == amc_pkg::ST_WAIT
                          || state_q == amc_pkg::ST_ACQ;
    assign tmr_if.unit_sec = unit_act_q;
    assign tmr_if.period   = per_act_q;

    amc_period_timer #(
        .MS_CYC (MS_CYC),
        .S_CYC  (S_CYC)
    ) u_timer (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .tmr       (tmr_if)
    );

    //------------------------------------------------------------------
    // Mode sequencer
    //------------------------------------------------------------------
    // Next state; a cleared start bit overrides everything.
    always_comb begin
        st_d = state_q;
        wake = 1'b0;
        if (!start) begin
            st_d = amc_pkg::ST_STOP;
        end else begin
            case (state_q)
                amc_pkg::ST_STOP: begin
                    st_d = stby ? amc_pkg::ST_WAIT : amc_pkg::ST_NORM;
                end
                amc_pkg::ST_NORM: begin
                    if (stby && !woke_q) begin
                        st_d = amc_pkg::ST_WAIT;
                    end
                end
                amc_pkg::ST_WAIT: begin
                    if (!stby) begin
                        st_d = amc_pkg::ST_NORM;
                    end else if (tmr_if.expire) begin
                        st_d = amc_pkg::ST_ACQ;
                    end
                end
                amc_pkg::ST_ACQ: begin
                    if (!stby) begin
                        st_d = amc_pkg::ST_NORM;
                    end else if (sample_valid_i && skip_cnt_q >= skip_lim) begin
                        if (mode == amc_pkg::MODE_STANDBY_THRESHOLD_MODE
                            && $signed(sample_current_i) > $signed(thr_act_q)) begin
                            st_d = amc_pkg::ST_NORM;
                            wake = 1'b1;
                        end else begin
                            st_d = amc_pkg::ST_WAIT;
                        end
                    end
                end
                default: st_d = amc_pkg::ST_STOP;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_q <= amc_pkg::ST_STOP;
        end else begin
            state_q <= st_d;
        end
    end

    // Samples seen since the shot; the first skip_lim are discarded.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state_q != amc_pkg::ST_ACQ) begin
            skip_cnt_q <= 4'h0;
        end else if (sample_valid_i && skip_cnt_q < skip_lim) begin
            skip_cnt_q <= skip_cnt_q + 4'h1;
        end
    end

    // Held in normal after a crossing until software rewrites the mode
    // register; a wake in the same cycle as that write is kept.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            woke_q <= 1'b0;
        end else if (wake) begin
            woke_q <= 1'b1;
        end else if (ctl_wr || st_d == amc_pkg::ST_STOP) begin
            woke_q <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    // Datapath controls follow the next state so they align with it.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            acq_run_o  <= 1'b0;
            acq_nom2_o <= 1'b0;
            acq_shot_o <= 1'b0;
        end else begin
            acq_run_o  <= st_d == amc_pkg::ST_NORM;
            acq_nom2_o <= st_d == amc_pkg::ST_NORM
                       && mode == amc_pkg::MODE_NOM2;
            acq_shot_o <= st_d == amc_pkg::ST_ACQ
                       && state_q == amc_pkg::ST_WAIT;
        end
    end

    // Indicator level rises on a standby-to-normal move and falls when
    // normal operation ends or the enable bit is cleared.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mode_change_indicator_pin_o <= 1'b0;
        end else if (ctl_q[amc_pkg::CTL_IND] && st_d == amc_pkg::ST_NORM
                     && (state_q == amc_pkg::ST_WAIT
                         || state_q == amc_pkg::ST_ACQ)) begin
            mode_change_indicator_pin_o <= 1'b1;
        end else if (!ctl_q[amc_pkg::CTL_IND] || st_d != amc_pkg::ST_NORM) begin
            mode_change_indicator_pin_o <= 1'b0;
        end
    end

    // Chopper clock divider; the pin stays low while gated off.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !ctl_q[amc_pkg::CTL_CHOP]) begin
            chop_cnt_q             <= '0;
            chopper_clock_output_o <= 1'b0;
        end else if (chop_cnt_q >= CW'(CHOP_HALF - 1)) begin
            chop_cnt_q             <= '0;
            chopper_clock_output_o <= !chopper_clock_output_o;
        end else begin
            chop_cnt_q <= chop_cnt_q + CW'(1);
        end
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    property p_mode_nom2;
        acq_nom2_o |-> $past(mode) == amc_pkg::MODE_NOM2 && acq_run_o;
    endproperty
    a_mode_nom2: assert property (p_mode_nom2)
        else $error("normal mode two flag without its mode code");

    property p_skip_done;
        (state_q == amc_pkg::ST_ACQ && st_d != amc_pkg::ST_ACQ && stby && start)
            |-> skip_cnt_q == skip_lim;
    endproperty
    a_skip_done: assert property (p_skip_done)
        else $error("standby compare before the discard count");

    property p_chop_off;
        !ctl_q[amc_pkg::CTL_CHOP] |=> !chopper_clock_output_o;
    endproperty
    a_chop_off: assert property (p_chop_off)
        else $error("chopper pin active while disabled");

    property p_ind_rise;
        $rose(mode_change_indicator_pin_o) |-> acq_run_o
            && $past(ctl_q[amc_pkg::CTL_IND])
            && ($past(state_q) == amc_pkg::ST_WAIT
                || $past(state_q) == amc_pkg::ST_ACQ);
    endproperty
    a_ind_rise: assert property (p_ind_rise)
        else $error("indicator rose without a standby exit");

    property p_stop;
        !start |=> state_q == amc_pkg::ST_STOP && !acq_run_o && !acq_shot_o;
    endproperty
    a_stop: assert property (p_stop)
        else $error("device left stop with start bit clear");

    property p_period_load;
        (wr_en_i && addr_i == amc_pkg::ADDR_TAL) |=>
            tmr_if.period == {$past(tah_q[6:0]), $past(wr_data_i)}
            && tmr_if.unit_sec == $past(tah_q[amc_pkg::TAH_UNIT]);
    endproperty
    a_period_load: assert property (p_period_load)
        else $error("period or unit not loaded from both registers");

    property p_thr_coherent;
        $changed(thr_act_q) |-> $past(wr_en_i && addr_i == amc_pkg::ADDR_ITL)
            && thr_act_q == {$past(ith_q), $past(wr_data_i)};
    endproperty
    a_thr_coherent: assert property (p_thr_coherent)
        else $error("threshold changed outside a low-byte write");

    property p_shot;
        (state_q == amc_pkg::ST_WAIT && tmr_if.expire && start && stby)
            |=> acq_shot_o && state_q == amc_pkg::ST_ACQ ##1 !acq_shot_o;
    endproperty
    a_shot: assert property (p_shot)
        else $error("period expiry did not give one shot");

    // Checked through reset itself, so this one needs its own disable.
    property p_unit_reset;
        disable iff (1'b0) srst_i |=> tah_q[amc_pkg::TAH_UNIT] && unit_act_q;
    endproperty
    a_unit_reset: assert property (p_unit_reset)
        else $error("period unit not set to seconds by reset");

    c_shot: cover property (acq_shot_o);
    c_wake: cover property (wake ##1 mode_change_indicator_pin_o);
    c_chop: cover property ($rose(chopper_clock_output_o));

endmodule
`default_nettype wire

// ===== test/amc_dp_model.sv
// Measurement datapath model that answers single-shot requests with samples.
`timescale 1ns/10ps
`default_nettype none
module amc_dp_model (
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // Shot request and sample plan.
    input  wire logic        acq_shot_i,
    input  wire logic [3:0]  hi_idx_i,
    input  wire logic [15:0] hi_val_i,
    input  wire logic [15:0] lo_val_i,
    // Samples towards the block.
    output logic             sample_valid_o,
    output logic      [15:0] sample_current_o
);
    //--------------------------------------------------------------
    // Sample generator
    //--------------------------------------------------------------
    logic [4:0] left_q;
    logic [3:0] idx_q;

    // Twelve samples per shot, one every other cycle; between samples the
    // bus flips each cycle so that stale data never looks like a sample.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            left_q           <= 5'h00;
            idx_q            <= 4'h0;
            sample_valid_o   <= 1'b0;
            sample_current_o <= 16'hA5A5;
        end else begin
            sample_valid_o   <= 1'b0;
            sample_current_o <= ~sample_current_o;
            if (acq_shot_i) begin
                left_q <= 5'h18;
                idx_q  <= 4'h0;
            end else if (left_q != 5'h00) begin
                left_q <= left_q - 5'h01;
                if (!left_q[0]) begin
                    sample_valid_o   <= 1'b1;
                    sample_current_o <= (idx_q == hi_idx_i) ? hi_val_i : lo_val_i;
                    idx_q            <= idx_q + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/acquisition_mode_control_tb_top.sv
// Self-checking bench for the acquisition mode control block.
`timescale 1ns/10ps
`default_nettype none
module acquisition_mode_control_tb_top;
    //--------------------------------------------------------------
    // Signals
    //--------------------------------------------------------------
    localparam int MS_C  = 4;
    localparam int S_C   = 16;
    localparam int CH_H  = 4;
    localparam int LIMIT = 20000;
    logic        clk;
    logic        srst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rdata;
    logic        valid;
    logic [15:0] cur;
    logic        run;
    logic        nom2;
    logic        shot;
    logic        chop;
    logic        ind_o;
    logic [3:0]  hi_idx;
    logic [15:0] hi_val;
    logic [15:0] lo_val;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;

    // Short counts keep the standby periods and chopper wave brief.
    amc_mode_ctrl #(.MS_CYC(MS_C), .S_CYC(S_C), .CHOP_HALF(CH_H)) i_dut (
        .sys_clk_i(clk), .srst_i(srst), .addr_i(addr), .wr_data_i(wdata),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rdata),
        .sample_valid_i(valid), .sample_current_i(cur), .acq_run_o(run),
        .acq_nom2_o(nom2), .acq_shot_o(shot), .chopper_clock_output_o(chop),
        .mode_change_indicator_pin_o(ind_o));

    amc_dp_model i_dp (
        .sys_clk_i(clk), .srst_i(srst), .acq_shot_i(shot), .hi_idx_i(hi_idx),
        .hi_val_i(hi_val), .lo_val_i(lo_val), .sample_valid_o(valid),
        .sample_current_o(cur));

    // Free-running clock, 25 ns period.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    //--------------------------------------------------------------
    // Tasks and expectations
    //--------------------------------------------------------------
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and still reaches the report.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmpr(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
        end
    endtask

    // Each access leaves one idle edge so no strobe is driven twice at once.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Counts the cycles in which the chopper pin or the shot pulse is high.
    task automatic count(input int n, input bit sel, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if ((sel ? chop : shot) === 1'b1) c++;
        end
    endtask

    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            amc_pkg::ADDR_CTL: return amc_pkg::RST_CTL;
            amc_pkg::ADDR_TAH: return amc_pkg::RST_TAH;
            amc_pkg::ADDR_TAL: return amc_pkg::RST_TAL;
            amc_pkg::ADDR_ITH: return amc_pkg::RST_ITH;
            default:           return amc_pkg::RST_ITL;
        endcase
    endfunction

    function automatic int exp_shots(input int unit, input int per, input int win);
        return win / (unit * per);
    endfunction

    // One standby-threshold attempt; sample k of each shot is above threshold.
    task automatic wake(input logic [2:0] code, input logic [3:0] k, input logic ind);
        int         w;
        logic       ex;
        logic [7:0] s;
        ex = (k == {1'b0, code} + 4'h3);
        wr(amc_pkg::ADDR_CTL, 8'h00);
        hi_idx <= k;
        wr(amc_pkg::ADDR_TAH, 8'h00);
        wr(amc_pkg::ADDR_TAL, 8'h10);
        wr(amc_pkg::ADDR_CTL, {2'b11, code, 1'b0, ind, 1'b1});
        w = 0;
        while (run !== 1'b1 && w < 200) begin
            @(posedge clk);
            #1;
            w++;
        end
        cmp1(run, ex);
        cmp1(ind_o, ex & ind);
        cmp1(nom2, 1'b0);
        rd(amc_pkg::ADDR_STAT, s);
        cmp8(s, ex ? 8'h0A : 8'h04);
    endtask

    //--------------------------------------------------------------
    // Test sequence
    //--------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] v [5];
        int         c;
        srst   = 1'b1;
        addr   = 8'h00;
        wdata  = 8'h00;
        wr_en  = 1'b0;
        rd_en  = 1'b0;
        hi_idx = 4'h0;
        hi_val = 16'h1235;
        lo_val = 16'h1234;
        void'($urandom(32'hE6AC));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        // Reset values, then an unmapped place.
        for (int a = 10; a < 15; a++) begin
            rd(8'(a), d);
            cmp8(d, rst_val(8'(a)));
        end
        rd(amc_pkg::ADDR_STAT, d);
        cmp8(d, 8'h01);
        rd(8'h20, d);
        cmp8(d, 8'h00);
        $display("test reset_values done");
        // Random readback; start bit kept clear, stray write to a hole.
        repeat (4) begin
            for (int i = 0; i < 5; i++) v[i] = 8'($urandom);
            v[0][0] = 1'b0;
            for (int i = 0; i < 5; i++) wr(8'(10 + i), v[i]);
            wr(8'h21, 8'($urandom));
            for (int i = 0; i < 5; i++) begin
                rd(8'(10 + i), d);
                cmp8(d, v[i]);
            end
        end
        $display("test readback done");
        // Every mode code with the start bit clear and then set.
        for (int m = 0; m < 4; m++) begin
            wr(amc_pkg::ADDR_CTL, {2'(m), 6'h00});
            repeat (3) @(posedge clk);
            #1;
            cmp1(run, 1'b0);
            wr(amc_pkg::ADDR_CTL, {2'(m), 6'h01});
            repeat (3) @(posedge clk);
            #1;
            cmp1(run, m < 2);
            cmp1(nom2, m == 1);
        end
        $display("test modes done");
        // Chopper pin: a square wave when enabled, quiet otherwise.
        wr(amc_pkg::ADDR_CTL, 8'h05);
        count(200, 1'b1, c);
        cmpr(c, 100 - CH_H, 100 + CH_H);
        wr(amc_pkg::ADDR_CTL, 8'h01);
        repeat (2) @(posedge clk);
        count(200, 1'b1, c);
        cmpr(c, 0, 0);
        $display("test chopper done");
        // Standby shots per period, milliseconds then seconds.
        wr(amc_pkg::ADDR_CTL, 8'h00);
        wr(amc_pkg::ADDR_TAH, 8'h00);
        wr(amc_pkg::ADDR_TAL, 8'h08);
        wr(amc_pkg::ADDR_CTL, 8'h81);
        count(480, 1'b0, c);
        c = c - exp_shots(MS_C, 8, 480);
        cmpr(c, -1, 1);
        cmp1(run, 1'b0);
        wr(amc_pkg::ADDR_CTL, 8'h00);
        wr(amc_pkg::ADDR_TAH, 8'h80);
        wr(amc_pkg::ADDR_TAL, 8'h03);
        wr(amc_pkg::ADDR_CTL, 8'h81);
        count(480, 1'b0, c);
        c = c - exp_shots(S_C, 3, 480);
        cmpr(c, -1, 1);
        $display("test standby_period done");
        // Threshold wake at the discard boundaries; equal value never wakes.
        wr(amc_pkg::ADDR_ITH, 8'h12);
        wr(amc_pkg::ADDR_ITL, 8'h34);
        wake(3'h0, 4'h3, 1'b1);
        wake(3'h0, 4'h2, 1'b1);
        wake(3'h7, 4'hA, 1'b1);
        wake(3'h7, 4'h9, 1'b1);
        wake(3'h3, 4'h6, 1'b0);
        d[2:0] = 3'($urandom);
        wake(d[2:0], {1'b0, d[2:0]} + 4'h3, 1'b1);
        // Upper byte alone must not move the working threshold.
        wr(amc_pkg::ADDR_ITH, 8'h7F);
        wake(3'h0, 4'h3, 1'b1);
        wr(amc_pkg::ADDR_ITL, 8'h34);
        hi_val <= 16'h7F35;
        lo_val <= 16'h7F34;
        wake(3'h0, 4'h4, 1'b1);
        wake(3'h0, 4'h3, 1'b1);
        $display("test threshold_wake done");
        final_report();
    end
endmodule
`default_nettype wire
